// *** hw/frame_pipeline_alignment.sv ***
// Contract
// - Each input stream fills a shift register over one 32-bit slot of each frame.
// - Frame alignment comes from frame pulse, or from strobe a.
// - All four channels finish in one frame, then outputs load.
// - Output appears exactly two frames after its input.
// - Linear mode drives a frame alignment strobe for a DSP port.
// - A delayed frame strobe lets devices chain on a 2048 kbit bus.
// - Frame-pulse mode ignores bit clock, uses internal 2048 kbit rate.
// - Strobed mode samples on bit clock fall, drives on rise.
`timescale 1ns/1ps
module frame_pipeline_alignment #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic strobed_serial_mode,
   input wire logic linear_mode,
   input wire logic bit_clk_in,
   input wire logic frame_pulse_in,
   input wire logic strobe_a_in,
   input wire logic strobe_b_in,
   input wire logic pcm_in_a,
   input wire logic compressed_in,
   output logic pcm_out_a,
   output logic pcm_out_a_oe,
   output logic compressed_out,
   output logic compressed_out_oe,
   output logic delayed_frame_out,
   output logic frame_align_out,
   output logic fifo_overflow
);
   localparam int W = frame_pipe_pkg::WORD_BITS;
   localparam int BW = frame_pipe_pkg::BIT_CNT_W;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] s_bclk, s_fp, s_sa, s_sb, s_pcm, s_cmp;
   logic bclk_q, fp_q, sa_q, sb_q;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_bclk <= 3'h0;
         s_fp <= 3'h0;
         s_sa <= 3'h0;
         s_sb <= 3'h0;
         s_pcm <= 3'h0;
         s_cmp <= 3'h0;
         bclk_q <= 1'b0;
         fp_q <= 1'b0;
         sa_q <= 1'b0;
         sb_q <= 1'b0;
      end
      else
      begin
         s_bclk <= {s_bclk[1:0], bit_clk_in};
         s_fp <= {s_fp[1:0], frame_pulse_in};
         s_sa <= {s_sa[1:0], strobe_a_in};
         s_sb <= {s_sb[1:0], strobe_b_in};
         s_pcm <= {s_pcm[1:0], pcm_in_a};
         s_cmp <= {s_cmp[1:0], compressed_in};
         if (s_bclk[1] == s_bclk[2])
            bclk_q <= s_bclk[2];
         if (s_fp[1] == s_fp[2])
            fp_q <= s_fp[2];
         if (s_sa[1] == s_sa[2])
            sa_q <= s_sa[2];
         if (s_sb[1] == s_sb[2])
            sb_q <= s_sb[2];
      end
   end

   wire bclk_agree = s_bclk[1] == s_bclk[2];
   wire bclk_rise_ext = bclk_agree && s_bclk[2] && !bclk_q;
   wire bclk_fall_ext = bclk_agree && !s_bclk[2] && bclk_q;
   wire fp_fall = (s_fp[1] == s_fp[2]) && !s_fp[2] && fp_q;
   wire sa_rise = (s_sa[1] == s_sa[2]) && s_sa[2] && !sa_q;
   wire sb_rise = (s_sb[1] == s_sb[2]) && s_sb[2] && !sb_q;

   // ****************************************
   // Internal bit rate for frame-pulse mode
   // ****************************************
   logic [frame_pipe_pkg::DIV_W-1:0] div_cnt;
   logic int_phase;
   // Each bit spans two half-bit ticks: sample on one, drive on the next.
   wire div_wrap = div_cnt ==
      frame_pipe_pkg::DIV_W'(frame_pipe_pkg::BUS_BIT_CYCLES / 2 - 1);
   wire int_tick = div_wrap && frame_pipe_pkg::BUS_BIT_CYCLES > 1;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_cnt <= '0;
         int_phase <= 1'b0;
      end
      else if (fp_fall || div_wrap)
      begin
         div_cnt <= '0;
         int_phase <= fp_fall ? 1'b1 : !int_phase;
      end
      else
      begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // Bit clock is ignored in frame-pulse mode.
   wire drive_edge = strobed_serial_mode ? bclk_rise_ext
                                         : (int_tick && !int_phase);
   wire sample_edge = strobed_serial_mode ? bclk_fall_ext
                                          : (int_tick && int_phase);
   // Strobe a marks the frame start; strobe b alone just re-aligns slots.
   wire frame_event = strobed_serial_mode ? sa_rise : fp_fall;

   // ****************************************
   // Bit counter and slot windows
   // ****************************************
   logic [BW-1:0] bit_cnt;
   logic [BW-1:0] b_cnt;
   logic b_active;
   wire in_slot_a = bit_cnt < BW'(W);
   wire in_slot_b = b_active && b_cnt < BW'(W);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         bit_cnt <= '1;
         b_cnt <= '1;
         b_active <= 1'b0;
      end
      else
      begin
         if (frame_event)
            bit_cnt <= '0;
         else if (sample_edge && bit_cnt != '1)
            bit_cnt <= bit_cnt + 1'b1;
         if (sb_rise || (!strobed_serial_mode && frame_event))
         begin
            b_cnt <= '0;
            b_active <= 1'b1;
         end
         else if (sample_edge && b_cnt != '1)
            b_cnt <= b_cnt + 1'b1;
      end
   end

   // ****************************************
   // Three-stage frame pipeline
   // ****************************************
   logic [W-1:0] sh_pcm, sh_cmp, tx_pcm, tx_cmp;
   logic [1:0] fill;
   logic word_ok;
   logic [BW-1:0] tx_a_cnt, tx_b_cnt;
   wire fifo_in_ready, fifo_out_valid;
   wire [2*W-1:0] fifo_out_data;
   wire b_start = sb_rise || (!strobed_serial_mode && frame_event);
   wire [W-1:0] word_pcm = fifo_out_valid ? fifo_out_data[2*W-1:W] : '0;
   wire [W-1:0] word_cmp = fifo_out_valid ? fifo_out_data[W-1:0] : '0;
   wire load_ok = frame_event ? fifo_out_valid : word_ok;
   wire [W-1:0] cmp_src = frame_event ? word_cmp : tx_cmp;
   wire shift_a = drive_edge && tx_a_cnt < BW'(W);
   wire shift_b = drive_edge && tx_b_cnt < BW'(W);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sh_pcm <= '0;
         sh_cmp <= '0;
         fill <= 2'h0;
         fifo_overflow <= 1'b0;
      end
      else
      begin
         if (sample_edge && in_slot_a)
            sh_pcm <= {sh_pcm[W-2:0], s_pcm[2]};
         if (sample_edge && in_slot_b)
            sh_cmp <= {sh_cmp[W-2:0], s_cmp[2]};
         if (frame_event)
         begin
            // The first event has no complete frame behind it yet.
            if (fill != 2'h2)
               fill <= fill + 2'h1;
            if (fill != 2'h0 && !fifo_in_ready)
               fifo_overflow <= 1'b1;
         end
      end
   end

   // The queue is the processing stage: a frame pushed at one event is
   // popped at the next, so output lags input by two frames.
   frame_word_fifo #(.WIDTH(2 * W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(frame_event && fill != 2'h0),
      .in_ready(fifo_in_ready),
      .in_data({sh_pcm, sh_cmp}),
      .out_valid(fifo_out_valid),
      .out_ready(frame_event),
      .out_data(fifo_out_data)
   );

   // The first bit of each slot leaves with its strobe; the counters stop
   // the shifting after exactly one word.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_pcm <= '0;
         tx_cmp <= '0;
         word_ok <= 1'b0;
         tx_a_cnt <= BW'(W);
         tx_b_cnt <= BW'(W);
      end
      else
      begin
         if (frame_event)
         begin
            word_ok <= fifo_out_valid;
            tx_pcm <= {word_pcm[W-2:0], 1'b0};
            tx_a_cnt <= BW'(1);
         end
         else if (shift_a)
         begin
            tx_pcm <= {tx_pcm[W-2:0], 1'b0};
            tx_a_cnt <= tx_a_cnt + 1'b1;
         end
         if (b_start)
         begin
            tx_cmp <= {cmp_src[W-2:0], 1'b0};
            tx_b_cnt <= BW'(1);
         end
         else if (frame_event)
            tx_cmp <= word_cmp;
         else if (shift_b)
         begin
            tx_cmp <= {tx_cmp[W-2:0], 1'b0};
            tx_b_cnt <= tx_b_cnt + 1'b1;
         end
      end
   end

   // ****************************************
   // Serial outputs and frame strobes
   // ****************************************
   logic [7:0] align_cnt;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pcm_out_a <= 1'b0;
         pcm_out_a_oe <= 1'b0;
         compressed_out <= 1'b0;
         compressed_out_oe <= 1'b0;
         delayed_frame_out <= 1'b0;
         frame_align_out <= 1'b0;
         align_cnt <= 8'h00;
      end
      else
      begin
         if (frame_event)
         begin
            pcm_out_a <= word_pcm[W-1];
            pcm_out_a_oe <= fifo_out_valid;
         end
         else if (drive_edge)
         begin
            pcm_out_a <= tx_pcm[W-1];
            pcm_out_a_oe <= shift_a && word_ok;
         end
         if (b_start)
         begin
            compressed_out <= cmp_src[W-1];
            compressed_out_oe <= load_ok;
         end
         else if (drive_edge)
         begin
            compressed_out <= tx_cmp[W-1];
            compressed_out_oe <= shift_b && word_ok;
         end
         // Pulse during the last bit of our four slots, for the next device.
         if (drive_edge)
            delayed_frame_out <= bit_cnt == BW'(W - 1);
         if (frame_event && linear_mode)
            align_cnt <= frame_pipe_pkg::FRAME_ALIGN_WIDTH;
         else if (drive_edge && align_cnt != 8'h00)
            align_cnt <= align_cnt - 8'h01;
         frame_align_out <= linear_mode && align_cnt != 8'h00;
      end
   end

endmodule : frame_pipeline_alignment

// *** hw/frame_pipe_pkg.sv ***
package frame_pipe_pkg;

   // Clock and link timing.
   localparam int CLK_HZ = 50_000_000;
   localparam int BUS_RATE_KBPS = 2048;
   localparam int BUS_BIT_CYCLES = (CLK_HZ / (BUS_RATE_KBPS * 1000)) > 0 ?
      (CLK_HZ / (BUS_RATE_KBPS * 1000)) : 1;
   localparam int FRAME_BITS = 256;
   localparam int STROBE_SPACING_MCLK = 512;

   // Slot layout: four channel slots of eight bits each per port.
   localparam int SLOT_BITS = 8;
   localparam int CHANNELS = 4;
   localparam int WORD_BITS = SLOT_BITS * CHANNELS;

   // Counter widths.
   localparam int BIT_CNT_W = 9;
   localparam int DIV_W = 8;

   localparam logic [7:0] FRAME_ALIGN_WIDTH = 8'h08;

endpackage : frame_pipe_pkg

// *** hw/frame_word_fifo.sv ***
`timescale 1ns/1ps
module frame_word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire do_push = in_valid && in_ready;
   wire do_pop = out_valid && out_ready;

   assign in_ready = count != (AW+1)'(DEPTH);
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk)
   begin
      if (do_push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (do_push)
         begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (do_pop)
         begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end

endmodule : frame_word_fifo

// *** tb/fpa_monitor.sv ***
`timescale 1ns/1ps
module fpa_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire logic strobed_serial_mode,
   input wire logic linear_mode,
   input wire logic bit_clk_in,
   input wire logic strobe_a_in,
   input wire logic pcm_out_a,
   input wire logic pcm_out_a_oe,
   input wire logic compressed_out_oe,
   input wire logic delayed_frame_out,
   input wire logic frame_align_out,
   input wire logic fifo_overflow
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   logic prev_a;
   logic [7:0] since_a;
   logic [9:0] run;
   wire a_rise = strobe_a_in && !prev_a;
   wire [7:0] next_since = since_a + {7'h00, since_a != 8'hFF};
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prev_a <= 1'b0;
         since_a <= 8'h00;
         run <= 10'h000;
      end
      else
      begin
         prev_a <= strobe_a_in;
         since_a <= a_rise ? 8'h00 : next_since;
         run <= pcm_out_a_oe ? run + 10'h001 : 10'h000;
      end
   end
   property p_warm;
      $rose(resetn) |-> (!pcm_out_a_oe) [*8];
   endproperty
   a_warm: assert property (p_warm)
      else $error("enable during warm-up");
   property p_edge;
      strobed_serial_mode && $past(pcm_out_a_oe) && pcm_out_a_oe
         && $changed(pcm_out_a) |->
         $past(bit_clk_in, 3) || $past(bit_clk_in, 4);
   endproperty
   a_edge: assert property (p_edge)
      else $error("data changed off bit clock rise");
   property p_sticky;
      fifo_overflow |=> fifo_overflow;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("overflow flag cleared");
   property p_align_off;
      (!linear_mode) [*4] |-> !frame_align_out;
   endproperty
   a_align_off: assert property (p_align_off)
      else $error("align strobe outside linear mode");
   property p_align_wide;
      $rose(frame_align_out) |-> frame_align_out [*8];
   endproperty
   a_align_wide: assert property (p_align_wide)
      else $error("align strobe too short");
   property p_chain;
      $fell(compressed_out_oe) |-> ##[1:1000] delayed_frame_out;
   endproperty
   a_chain: assert property (p_chain)
      else $error("no delayed frame strobe");
   property p_slot;
      run <= (strobed_serial_mode ? 10'h10E : 10'h30C);
   endproperty
   a_slot: assert property (p_slot)
      else $error("enable held past slot");
   property p_start;
      $rose(pcm_out_a_oe) && strobed_serial_mode |-> since_a < 8'h28;
   endproperty
   a_start: assert property (p_start)
      else $error("slot not aligned to strobe");
endmodule : fpa_monitor
bind frame_pipeline_alignment fpa_monitor i_mon (.clk, .resetn,
   .strobed_serial_mode, .linear_mode, .bit_clk_in, .strobe_a_in,
   .pcm_out_a, .pcm_out_a_oe, .compressed_out_oe, .delayed_frame_out,
   .frame_align_out, .fifo_overflow);

// *** tb/tdm_master.sv ***
`timescale 1ns/1ps
module tdm_master (
   input wire logic run,
   input wire logic [31:0] pcm_word,
   input wire logic [31:0] cmp_word,
   output logic bit_clk,
   output logic strobe_a,
   output logic strobe_b,
   output logic pcm_d,
   output logic cmp_d,
   output int frame
);
   logic [31:0] pw;
   logic [31:0] cw;
   initial
   begin
      bit_clk = 1'b0;
      strobe_a = 1'b0;
      strobe_b = 1'b0;
      pcm_d = 1'b0;
      cmp_d = 1'b1;
      frame = 0;
      forever
      begin
         wait (run);
         for (int b = 0; b < 80; b++)
         begin
            #80 bit_clk = 1'b1;
            #1;
            if (b == 0)
            begin
               pw = pcm_word;
               cw = cmp_word;
               frame = frame + 1;
            end
            strobe_a = b < 8;
            strobe_b = b >= 40 && b < 48;
            pcm_d = b < 32 ? pw[31-b] : ~pcm_d;
            cmp_d = b >= 40 && b < 72 ? cw[71-b] : ~cmp_d;
            #79 bit_clk = 1'b0;
         end
      end
   end
endmodule : tdm_master

// *** tb/test_frame_pipeline_alignment.sv ***
`timescale 1ns/1ps
module test_frame_pipeline_alignment;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic linear_mode = 1'b1;
   logic run = 1'b0;
   logic [31:0] pw = 32'h00000000;
   logic [31:0] cw = 32'hFFFFFFFF;
   logic [31:0] sp [0:15];
   logic [31:0] sc [0:15];
   logic [31:0] sh [0:1];
   int nb [0:1] = '{0, 0};
   int nrx [0:1] = '{0, 0};
   int frame;
   int failures = 0;
   int n_checks = 0;
   int seed = 53;
   int aligns = 0;
   wire bclk, sa, sb, pi, ci, po, poe, co, coe, fao, ovf;
   always #10 clk = ~clk;
   tdm_master i_far (.run(run), .pcm_word(pw), .cmp_word(cw),
      .bit_clk(bclk), .strobe_a(sa), .strobe_b(sb), .pcm_d(pi),
      .cmp_d(ci), .frame(frame));
   frame_pipeline_alignment i_dut (.clk(clk), .resetn(resetn),
      .strobed_serial_mode(1'b1), .linear_mode(linear_mode),
      .bit_clk_in(bclk), .frame_pulse_in(1'b1), .strobe_a_in(sa),
      .strobe_b_in(sb), .pcm_in_a(pi), .compressed_in(ci),
      .pcm_out_a(po), .pcm_out_a_oe(poe), .compressed_out(co),
      .compressed_out_oe(coe), .delayed_frame_out(),
      .frame_align_out(fao), .fifo_overflow(ovf));
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task end_sim();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task take(input int s, input logic b);
      sh[s] = {sh[s][30:0], b};
      nb[s]++;
      if (nb[s] == 32)
      begin
         nb[s] = 0;
         nrx[s]++;
         chk(s ? "cmp" : "pcm", s ? sc[frame-2] : sp[frame-2], sh[s]);
      end
   endtask : take
   task next_frame();
      int f0;
      f0 = frame;
      for (int i = 0; i < 1000 && frame == f0; i++)
         @(posedge clk);
      if (frame == f0)
      begin
         failures++;
         $display("ERROR frame expected event seen none");
         end_sim();
      end
      else
         #1;
   endtask : next_frame
   always @(posedge bclk)
   begin
      if (poe === 1'b1)
         take(0, po);
      if (coe === 1'b1)
         take(1, co);
   end
   always @(posedge clk)
      if (fao === 1'b1 && linear_mode)
         aligns++;
   initial
   begin
      repeat (6) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge clk);
      #1 run = 1'b1;
      for (int f = 1; f <= 13; f++)
      begin
         next_frame();
         sp[frame] = pw;
         sc[frame] = cw;
         pw = f == 1 ? 32'h80000001 : $random(seed);
         cw = f == 1 ? 32'h7FFFFFFE : $random(seed);
         if (f == 6)
         begin
            repeat (200) @(posedge clk);
            #1 linear_mode = 1'b0;
         end
      end
      chk("pcm words", 32'h0000000A, 32'(nrx[0]));
      chk("cmp words", 32'h0000000A, 32'(nrx[1]));
      chk("align seen", 32'h00000001, {31'h0, aligns > 0});
      chk("overflow", 32'h00000000, {31'h0, ovf});
      end_sim();
   end
endmodule : test_frame_pipeline_alignment
